// *** core/counter_array_pkg.sv ***
package counter_array_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register addresses
	localparam logic [7:0] ADDR_CONTROL      = 8'hD8;
	localparam logic [7:0] ADDR_MODE         = 8'hD9;
	localparam logic [7:0] ADDR_MODULE2_MODE = 8'hDC;
	localparam logic [7:0] ADDR_COUNT_LOW    = 8'hF9;
	localparam logic [7:0] ADDR_COUNT_HIGH   = 8'hFA;
	localparam logic [7:0] ADDR_RELOAD_OFS   = 8'hEB;
	localparam logic [7:0] ADDR_COMPARE_HIGH = 8'hFB;

	////////////////////////////////////////////////////////////////////////////
	// control register fields
	localparam int BIT_OVERFLOW_FLAG = 7;
	localparam int BIT_RUN           = 6;
	localparam int BIT_MOD2_FLAG     = 2;
	localparam int BIT_MOD1_FLAG     = 1;
	localparam int BIT_MOD0_FLAG     = 0;

	// mode register fields
	localparam int BIT_IDLE_SUSPEND  = 7;
	localparam int BIT_WDT_ENABLE    = 6;
	localparam int BIT_WDT_LOCK      = 5;
	localparam int BIT_CLKSEL_HI     = 3;
	localparam int BIT_CLKSEL_LO     = 1;
	localparam int BIT_OVF_IRQ_EN    = 0;

	////////////////////////////////////////////////////////////////////////////
	// clock select codes and divisors
	localparam logic [2:0] CLKSEL_DIV12   = 3'h0;
	localparam logic [2:0] CLKSEL_DIV4    = 3'h1;
	localparam logic [2:0] CLKSEL_TIMER   = 3'h2;
	localparam logic [2:0] CLKSEL_EXT     = 3'h3;
	localparam logic [2:0] CLKSEL_SYSTEM_CLOCK  = 3'h4;
	localparam logic [2:0] CLKSEL_EXTDIV8 = 3'h5;
	localparam logic [3:0] DIVIDE_12      = 4'hC;
	localparam logic [3:0] DIVIDE_4       = 4'h4;

	////////////////////////////////////////////////////////////////////////////
	// reset values, forced fields and the all-ones count byte
	localparam logic [7:0] RESET_BYTE       = 8'h00;
	localparam logic       RESET_WDT_ENABLE = 1'b1;
	localparam logic [7:0] MOD2_TIMER_MODE  = 8'h48;
	localparam logic [7:0] BYTE_ALL_ONES    = 8'hFF;

endpackage

// *** core/counter_array_watchdog.sv ***
`timescale 1ns/1ps
module counter_array_watchdog (
	input  wire logic       clock,
	input  wire logic       reset,
	input  wire logic       clockEnable,
	input  wire logic [7:0] regAddr,
	input  wire logic       regWrite,
	input  wire logic [7:0] regWriteData,
	input  wire logic       regRead,
	output logic      [7:0] regReadData,
	input  wire logic       cpuIdle,
	input  wire logic       timerOverflowTick,
	input  wire logic       externalTick,
	output logic            watchdogReset,
	output logic            watchdogEnabled,
	output logic            counterTick
);

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic [3:0] prescale;
		logic [7:0] countLow;
		logic [7:0] countHigh;
		logic [7:0] compareHigh;
		logic [7:0] reloadOffset;
		logic [7:0] module2Mode;
		logic       overflowFlag;
		logic       runBit;
		logic [2:0] moduleFlags;
		logic       idleSuspend;
		logic       enableBit;
		logic       lockBit;
		logic [2:0] clockSelect;
		logic       overflowIrqEn;
		logic       resetReq;
		logic [7:0] readData;
	} state_t;

	state_t st_q;
	state_t st_d;

	logic       enabled;
	logic       running;
	logic [3:0] divisor;
	logic       tick;
	logic       lowOverflow;
	logic       wrControl;
	logic       wrMode;
	logic [7:0] readValue;

	////////////////////////////////////////////////////////////////////////////
	// timebase

	assign enabled = st_q.enableBit | st_q.lockBit;
	// counter runs on the software run bit or while enabled, and stops while idle suspend is set and the cpu is idle
	assign running = (st_q.runBit | enabled)
		& ~(st_q.idleSuspend & cpuIdle);

	always_comb begin
		divisor = 4'h1;
		unique case (st_q.clockSelect)
			counter_array_pkg::CLKSEL_DIV12: divisor = counter_array_pkg::DIVIDE_12;
			counter_array_pkg::CLKSEL_DIV4:  divisor = counter_array_pkg::DIVIDE_4;
			default:                         divisor = 4'h1;
		endcase
	end

	// one-cycle strobe in the system clock domain
	always_comb begin
		unique case (st_q.clockSelect)
			counter_array_pkg::CLKSEL_DIV12,
			counter_array_pkg::CLKSEL_DIV4:
				tick = running & (st_q.prescale == divisor - 4'h1);
			counter_array_pkg::CLKSEL_TIMER:  tick = running & timerOverflowTick;
			counter_array_pkg::CLKSEL_EXT,
			counter_array_pkg::CLKSEL_EXTDIV8: tick = running & externalTick;
			counter_array_pkg::CLKSEL_SYSTEM_CLOCK: tick = running;
			default:                          tick = 1'b0;
		endcase
	end

	assign lowOverflow = tick & (st_q.countLow == counter_array_pkg::BYTE_ALL_ONES);
	assign wrControl   = regWrite & (regAddr == counter_array_pkg::ADDR_CONTROL);
	assign wrMode      = regWrite & (regAddr == counter_array_pkg::ADDR_MODE);

	////////////////////////////////////////////////////////////////////////////
	// read mux

	always_comb begin
		readValue = 8'h00;
		unique case (regAddr)
			counter_array_pkg::ADDR_CONTROL: begin
				readValue[counter_array_pkg::BIT_OVERFLOW_FLAG] = st_q.overflowFlag;
				readValue[counter_array_pkg::BIT_RUN] = st_q.runBit;
				readValue[2:0] = st_q.moduleFlags;
			end
			counter_array_pkg::ADDR_MODE: begin
				readValue[counter_array_pkg::BIT_IDLE_SUSPEND] = st_q.idleSuspend;
				readValue[counter_array_pkg::BIT_WDT_ENABLE] = st_q.enableBit;
				readValue[counter_array_pkg::BIT_WDT_LOCK] = st_q.lockBit;
				readValue[counter_array_pkg::BIT_CLKSEL_HI:counter_array_pkg::BIT_CLKSEL_LO]
					= st_q.clockSelect;
				readValue[counter_array_pkg::BIT_OVF_IRQ_EN] = st_q.overflowIrqEn;
			end
			counter_array_pkg::ADDR_MODULE2_MODE:
				readValue = enabled ? counter_array_pkg::MOD2_TIMER_MODE
					: st_q.module2Mode;
			counter_array_pkg::ADDR_COUNT_LOW:    readValue = st_q.countLow;
			counter_array_pkg::ADDR_COUNT_HIGH:   readValue = st_q.countHigh;
			counter_array_pkg::ADDR_RELOAD_OFS:   readValue = st_q.reloadOffset;
			counter_array_pkg::ADDR_COMPARE_HIGH: readValue = st_q.compareHigh;
			default:                              readValue = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		st_d = st_q;
		if (regRead) begin
			st_d.readData = readValue;
		end
		// prescaler
		if (running) begin
			st_d.prescale = (st_q.prescale >= divisor - 4'h1) ? 4'h0
				: st_q.prescale + 4'h1;
		end
		// software writes
		if (wrControl) begin
			st_d.overflowFlag = regWriteData[counter_array_pkg::BIT_OVERFLOW_FLAG];
			st_d.runBit = regWriteData[counter_array_pkg::BIT_RUN];
			st_d.moduleFlags = regWriteData[2:0];
		end
		if (wrMode) begin
			if (!enabled) begin
				st_d.idleSuspend = regWriteData[counter_array_pkg::BIT_IDLE_SUSPEND];
				st_d.clockSelect = regWriteData[counter_array_pkg::BIT_CLKSEL_HI:
					counter_array_pkg::BIT_CLKSEL_LO];
			end
			// lock is only ever set by software
			if (regWriteData[counter_array_pkg::BIT_WDT_LOCK]) begin
				st_d.lockBit = 1'b1;
			end
			st_d.enableBit = regWriteData[counter_array_pkg::BIT_WDT_ENABLE];
			st_d.overflowIrqEn = regWriteData[counter_array_pkg::BIT_OVF_IRQ_EN];
		end
		if (regWrite && !enabled) begin
			unique case (regAddr)
				counter_array_pkg::ADDR_MODULE2_MODE: st_d.module2Mode = regWriteData;
				counter_array_pkg::ADDR_COUNT_LOW:    st_d.countLow = regWriteData;
				counter_array_pkg::ADDR_COUNT_HIGH:   st_d.countHigh = regWriteData;
				default: ;
			endcase
		end
		if (regWrite && regAddr == counter_array_pkg::ADDR_RELOAD_OFS) begin
			st_d.reloadOffset = regWriteData;
		end
		// counting wins over a blocked write and over a flag clear
		if (tick) begin
			st_d.countLow = st_q.countLow + 8'h01;
			if (lowOverflow) begin
				st_d.countHigh = st_q.countHigh + 8'h01;
				if (st_q.countHigh == counter_array_pkg::BYTE_ALL_ONES) begin
					st_d.overflowFlag = 1'b1;
				end
			end
		end
		if (regWrite && regAddr == counter_array_pkg::ADDR_COMPARE_HIGH) begin
			// refresh: timeout 256*offset + (256 - low byte)
			st_d.compareHigh = enabled ? st_q.countHigh + st_q.reloadOffset
				: regWriteData;
		end
		// watchdog expiry and forced reset
		if (enabled && lowOverflow && st_q.countHigh == st_q.compareHigh) begin
			st_d.resetReq = 1'b1;
		end
		if (enabled && wrControl && regWriteData[counter_array_pkg::BIT_MOD2_FLAG]) begin
			st_d.resetReq = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st_q <= '0;
			st_q.enableBit <= counter_array_pkg::RESET_WDT_ENABLE;
			st_q.clockSelect <= counter_array_pkg::CLKSEL_DIV12;
			st_q.countLow <= counter_array_pkg::RESET_BYTE;
			st_q.reloadOffset <= counter_array_pkg::RESET_BYTE;
		end else if (clockEnable) begin
			st_q <= st_d;
		end
	end

	assign regReadData     = st_q.readData;
	assign watchdogReset   = st_q.resetReq;
	assign watchdogEnabled = enabled;
	assign counterTick     = tick & clockEnable;

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clock iff clockEnable); endclocking
	default disable iff (reset);

	chk_expiry_reset: assert property (
		enabled && lowOverflow && st_q.countHigh == st_q.compareHigh
		|=> watchdogReset)
		else $error("no reset on expiry");
	chk_forced_reset: assert property (
		enabled && wrControl && regWriteData[counter_array_pkg::BIT_MOD2_FLAG]
		|=> watchdogReset)
		else $error("flag write did not force reset");
	chk_refresh_load: assert property (
		enabled && regWrite && regAddr == counter_array_pkg::ADDR_COMPARE_HIGH
		|=> st_q.compareHigh == $past(st_q.countHigh) + $past(st_q.reloadOffset))
		else $error("refresh loaded wrong value");
	chk_count_blocked: assert property (
		enabled && !tick && regWrite && regAddr == counter_array_pkg::ADDR_COUNT_HIGH
		|=> $stable(st_q.countHigh))
		else $error("counter written while enabled");
	chk_select_frozen: assert property (
		enabled && wrMode |=> $stable(st_q.clockSelect) && $stable(st_q.idleSuspend))
		else $error("clock select changed while enabled");
	chk_lock_holds: assert property (
		st_q.lockBit |=> enabled [*8])
		else $error("locked watchdog disabled");
	chk_lock_enables: assert property (
		wrMode && regWriteData[counter_array_pkg::BIT_WDT_LOCK] |=> enabled)
		else $error("lock did not enable");
	chk_clear_disables: assert property (
		wrMode && !st_q.lockBit && regWriteData[6:5] == 2'b00 |=> !enabled)
		else $error("enable clear ignored");
	chk_tick_single: assert property (
		tick && st_q.clockSelect == counter_array_pkg::CLKSEL_DIV12 |=> !tick [*8])
		else $error("divide by 12 strobe too frequent");
	chk_reset_sticky: assert property (
		watchdogReset |=> watchdogReset)
		else $error("reset request dropped");
	chk_forced_on: assert property (
		enabled && !(st_q.idleSuspend && cpuIdle) |-> running)
		else $error("counter stopped while enabled");

	cov_expiry:  cover property (enabled && lowOverflow
		&& st_q.countHigh == st_q.compareHigh);
	cov_refresh: cover property (enabled && regWrite
		&& regAddr == counter_array_pkg::ADDR_COMPARE_HIGH);
	cov_lock:    cover property (st_q.lockBit && wrMode);
	cov_disable: cover property (enabled ##1 !enabled);

endmodule // counter_array_watchdog

// *** tb/counter_array_watchdog_tb.sv ***
`timescale 1ns/1ps
module counter_array_watchdog_tb;
	logic       clock = 1'b0;
	logic       reset = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic       regWrite = 1'b0;
	logic [7:0] regWriteData = 8'h00;
	logic       regRead = 1'b0;
	logic [7:0] regReadData;
	logic       timerOverflowTick = 1'b0;
	logic       clockEnable = 1'b1;
	logic       cpuIdle = 1'b0;
	logic       watchdogReset;
	logic       watchdogEnabled;
	logic       counterTick;
	int         bad_count = 0;
	int         checked = 0;

	always #10 clock = ~clock;

	counter_array_watchdog i_dut (
		.clock(clock), .reset(reset), .clockEnable(clockEnable),
		.regAddr(regAddr), .regWrite(regWrite),
		.regWriteData(regWriteData), .regRead(regRead),
		.regReadData(regReadData), .cpuIdle(cpuIdle),
		.timerOverflowTick(timerOverflowTick), .externalTick(1'b0),
		.watchdogReset(watchdogReset), .watchdogEnabled(watchdogEnabled),
		.counterTick(counterTick)
	);

	////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test;
		if (bad_count == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input string what, input logic [7:0] seen, exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic doReset;
		@(posedge clock);
		reset <= 1'b1;
		repeat (6) @(posedge clock);
		reset <= 1'b0;
		#1;
	endtask

	task automatic wr(input logic [7:0] addr, data);
		@(posedge clock);
		regAddr <= addr;
		regWriteData <= data;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		#1;
	endtask

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge clock);
		regAddr <= addr;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		data = regReadData;
	endtask

	task automatic tick;
		@(posedge clock);
		timerOverflowTick <= 1'b1;
		#1;
		check("counterTick", 8'(counterTick), 8'h01);
		@(posedge clock);
		timerOverflowTick <= 1'b0;
		#1;
		check("counterTick low", 8'(counterTick), 8'h00);
	endtask

	////////////////////////////////////////////////////////////////////////////
	task automatic s_defaults;
		logic [7:0] v;
		doReset();
		check("enabled", 8'(watchdogEnabled), 8'h01);
		rd(counter_array_pkg::ADDR_MODE, v);
		check("mode", v, 8'h40);
		rd(counter_array_pkg::ADDR_CONTROL, v);
		check("control", v, 8'h00);
		rd(counter_array_pkg::ADDR_MODULE2_MODE, v);
		check("mod2 mode", v, counter_array_pkg::MOD2_TIMER_MODE);
		wr(counter_array_pkg::ADDR_MODE, 8'hC2);
		rd(counter_array_pkg::ADDR_MODE, v);
		check("frozen mode", v, 8'h40);
	endtask

	task automatic s_default_timeout;
		int n;
		doReset();
		n = 0;
		while (watchdogReset !== 1'b1 && n < 4000) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 4000) begin
			bad_count++;
			end_of_test();
		end
		check("timeout high", n[15:8], 8'(counter_array_pkg::DIVIDE_12));
		check("timeout low", n[7:0], counter_array_pkg::RESET_BYTE);
	endtask

	task automatic s_forced;
		doReset();
		wr(counter_array_pkg::ADDR_CONTROL, 8'h04);
		check("forced", 8'(watchdogReset), 8'h01);
	endtask

	task automatic s_lock_disable;
		doReset();
		wr(counter_array_pkg::ADDR_MODE, 8'h00);
		check("disabled", 8'(watchdogEnabled), 8'h00);
		wr(counter_array_pkg::ADDR_CONTROL, 8'h04);
		check("no force", 8'(watchdogReset), 8'h00);
		wr(counter_array_pkg::ADDR_MODE, 8'h20);
		check("lock on", 8'(watchdogEnabled), 8'h01);
		wr(counter_array_pkg::ADDR_MODE, 8'h00);
		check("locked", 8'(watchdogEnabled), 8'h01);
		doReset();
		wr(counter_array_pkg::ADDR_MODE, 8'h00);
		check("unlocked", 8'(watchdogEnabled), 8'h00);
	endtask

	task automatic s_refresh;
		logic [7:0] v;
		wr(counter_array_pkg::ADDR_COUNT_LOW, 8'hF0);
		wr(counter_array_pkg::ADDR_COUNT_HIGH, 8'h00);
		wr(counter_array_pkg::ADDR_RELOAD_OFS, 8'h01);
		wr(counter_array_pkg::ADDR_MODE, 8'h04);
		wr(counter_array_pkg::ADDR_MODE, 8'h44);
		wr(counter_array_pkg::ADDR_COUNT_LOW, 8'h00);
		rd(counter_array_pkg::ADDR_COUNT_LOW, v);
		check("count low", v, 8'hF0);
		wr(counter_array_pkg::ADDR_COMPARE_HIGH, 8'h77);
		rd(counter_array_pkg::ADDR_COMPARE_HIGH, v);
		check("compare", v, 8'h01);
		repeat (271) tick();
		check("early", 8'(watchdogReset), 8'h00);
		tick();
		check("expired", 8'(watchdogReset), 8'h01);
	endtask

	task automatic s_clock_modes;
		logic [7:0] a;
		logic [7:0] b;
		doReset();
		wr(counter_array_pkg::ADDR_MODE, 8'h00);
		wr(counter_array_pkg::ADDR_MODE, 8'h88);
		wr(counter_array_pkg::ADDR_MODE, 8'hC8);
		wr(counter_array_pkg::ADDR_MODE, 8'h42);
		rd(counter_array_pkg::ADDR_MODE, a);
		check("idle frozen", a, 8'hC8);
		wr(counter_array_pkg::ADDR_CONTROL, 8'h00);
		@(posedge clock);
		cpuIdle <= 1'b1;
		#1;
		check("idle tick", 8'(counterTick), 8'h00);
		rd(counter_array_pkg::ADDR_COUNT_LOW, a);
		rd(counter_array_pkg::ADDR_COUNT_LOW, b);
		check("idle count", b, a);
		@(posedge clock);
		cpuIdle <= 1'b0;
		#1;
		check("run tick", 8'(counterTick), 8'h01);
		rd(counter_array_pkg::ADDR_COUNT_LOW, a);
		@(posedge clock);
		clockEnable <= 1'b0;
		#1;
		check("frozen tick", 8'(counterTick), 8'h00);
		repeat (8) @(posedge clock);
		clockEnable <= 1'b1;
		rd(counter_array_pkg::ADDR_COUNT_LOW, b);
		check("frozen count", b, a + 8'h03);
		check("no expiry", 8'(watchdogReset), 8'h00);
	endtask

	initial begin
		s_defaults();
		s_default_timeout();
		s_forced();
		s_lock_disable();
		s_refresh();
		s_clock_modes();
		end_of_test();
	end
endmodule // counter_array_watchdog_tb
